// File: hdl/rtcal_top.sv
// RTC alarm and calibration block with APB register slave
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtcal_top
   import rtcal_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tb_tick,
   input wire rtcal_time_t cur_time,
   output logic irq,
   output logic alarm_pulse,
   output logic sec_pulse
);
   rtcal_cfg_t cfg_reg;
   rtcal_cfg_t cfg_next;
   rtcal_alarm_t alm_reg;
   logic [7:0] trim_reg;
   logic run_reg;
   logic [STS_W-1:0] sts_reg;
   logic [STS_W-1:0] sts_next;
   logic [STS_W-1:0] ien_reg;
   logic eval_half_reg;
   logic eval_sec_reg;
   logic half_tick;
   logic sync_flag;
   logic acc_done;
   logic wr_done;
   logic win_touch;
   logic a_cfg;
   logic a_val;
   logic a_trim;
   logic a_sts;
   logic a_clr;
   logic a_ien;
   logic map_ok;
   logic [31:0] rd_val;
   logic hit;
   logic alm_evt;
   logic feb29;

   function automatic logic [7:0] win_upper(input logic [1:0] ptr, input rtcal_alarm_t a);
      logic [7:0] v;
      v = 8'h00;
      case (ptr)
         2'h0: v = a.minute;
         2'h1: v = {5'h00, a.wday};
         2'h2: v = a.month;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : win_upper

   function automatic logic [7:0] win_lower(input logic [1:0] ptr, input rtcal_alarm_t a);
      logic [7:0] v;
      v = 8'h00;
      case (ptr)
         2'h0: v = a.second;
         2'h1: v = a.hour;
         2'h2: v = a.day;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : win_lower

   function automatic logic bcd_leap(input logic [7:0] y);
      if (y[4]) begin
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction : bcd_leap

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer registered
   assign acc_done = psel && penable && pready;
   assign wr_done = acc_done && pwrite;
   // Read of the window, or a write reaching its upper byte
   assign win_touch = acc_done && a_val && (!pwrite || pstrb[1]);

   always_comb begin
      a_cfg = 1'b0;
      a_val = 1'b0;
      a_trim = 1'b0;
      a_sts = 1'b0;
      a_clr = 1'b0;
      a_ien = 1'b0;
      rd_val = 32'h0000_0000;
      if (paddr == RA_CFG) begin
         a_cfg = 1'b1;
         rd_val = {16'h0000, cfg_reg};
      end else if (paddr == RA_VAL) begin
         a_val = 1'b1;
         rd_val = {16'h0000, win_upper(cfg_reg.ptr, alm_reg), win_lower(cfg_reg.ptr, alm_reg)};
      end else if (paddr == RA_TRIM) begin
         a_trim = 1'b1;
         rd_val = {22'h000000, sync_flag, run_reg, trim_reg};
      end else if (paddr == RA_STS) begin
         a_sts = 1'b1;
         rd_val = {30'h00000000, sts_reg};
      end else if (paddr == RA_CLR) begin
         a_clr = 1'b1;
      end else if (paddr == RA_IEN) begin
         a_ien = 1'b1;
         rd_val = {30'h00000000, ien_reg};
      end
      map_ok = a_cfg || a_val || a_trim || a_sts || a_clr || a_ien;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !map_ok;
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration: hardware updates first, a software byte write wins
   always_comb begin
      cfg_next = cfg_reg;
      if (alm_evt) begin
         if (cfg_reg.rpt != RPT_ZERO) begin
            cfg_next.rpt = cfg_reg.rpt - 8'h01;
         end else if (cfg_reg.chime) begin
            cfg_next.rpt = RPT_FULL;
         end else begin
            cfg_next.on = 1'b0;
         end
      end
      if (win_touch && cfg_reg.ptr != PTR_ZERO) begin
         cfg_next.ptr = cfg_reg.ptr - 2'h1;
      end
      if (wr_done && a_cfg) begin
         if (pstrb[1]) begin
            cfg_next[15:8] = pwdata[15:8];
         end
         if (pstrb[0]) begin
            cfg_next[7:0] = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= CFG_RST;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // Alarm values through the window, field chosen by the pointer before it moves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alm_reg <= ALM_RST;
      end else if (wr_done && a_val) begin
         if (pstrb[1]) begin
            case (cfg_reg.ptr)
               2'h0: alm_reg.minute <= pwdata[15:8];
               2'h1: alm_reg.wday <= pwdata[10:8];
               2'h2: alm_reg.month <= pwdata[15:8];
               default: ;
            endcase
         end
         if (pstrb[0]) begin
            case (cfg_reg.ptr)
               2'h0: alm_reg.second <= pwdata[7:0];
               2'h1: alm_reg.hour <= pwdata[7:0];
               2'h2: alm_reg.day <= pwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_reg <= TRIM_RST;
         run_reg <= 1'b0;
      end else if (wr_done && a_trim) begin
         if (pstrb[0]) begin
            trim_reg <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            run_reg <= pwdata[TRIM_RUN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time base; trim applies at the rollover that ends second 59
   rtcal_prescale u_prescale (
      .pclk(pclk),
      .presetn(presetn),
      .tb_tick(tb_tick),
      .run(run_reg),
      .cal_apply(cur_time.second == BCD_S59),
      .trim(trim_reg),
      .half_tick(half_tick),
      .sec_tick(sec_pulse),
      .sync_flag(sync_flag)
   );

   // Compare one cycle after the tick so the calendar has moved to the new second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eval_half_reg <= 1'b0;
         eval_sec_reg <= 1'b0;
      end else begin
         eval_half_reg <= half_tick;
         eval_sec_reg <= sec_pulse;
      end
   end

   assign feb29 = (alm_reg.month == BCD_FEB) && (alm_reg.day == BCD_D29);

   // Reserved codes never match: a stray value silences the alarm
   always_comb begin
      hit = 1'b0;
      case (rtcal_iv_t'(cfg_reg.iv))
         IV_HALF: hit = eval_half_reg;
         IV_SEC: hit = eval_sec_reg;
         IV_TENSEC: hit = eval_sec_reg && alm_reg.second[3:0] == cur_time.second[3:0];
         IV_MIN: hit = eval_sec_reg && alm_reg.second == cur_time.second;
         IV_TENMIN: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute[3:0] == cur_time.minute[3:0];
         IV_HOUR: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute == cur_time.minute;
         IV_DAY: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute == cur_time.minute && alm_reg.hour == cur_time.hour;
         IV_WEEK: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute == cur_time.minute && alm_reg.hour == cur_time.hour
            && alm_reg.wday == cur_time.wday;
         IV_MONTH: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute == cur_time.minute && alm_reg.hour == cur_time.hour
            && alm_reg.day == cur_time.day;
         IV_YEAR: hit = eval_sec_reg && alm_reg.second == cur_time.second
            && alm_reg.minute == cur_time.minute && alm_reg.hour == cur_time.hour
            && alm_reg.day == cur_time.day && alm_reg.month == cur_time.month
            && (!feb29 || bcd_leap(cur_time.year));
         default: hit = 1'b0;
      endcase
   end

   assign alm_evt = cfg_reg.on && hit;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky status, set wins over a same-cycle clear
   always_comb begin
      sts_next = sts_reg;
      if (wr_done && a_clr && pstrb[0]) begin
         sts_next = sts_reg & ~pwdata[STS_W-1:0];
      end
      sts_next[STS_ALARM] = sts_next[STS_ALARM] || alm_evt;
      sts_next[STS_SEC] = sts_next[STS_SEC] || sec_pulse;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_reg <= STS_RST;
         ien_reg <= STS_RST;
         irq <= 1'b0;
      end else begin
         sts_reg <= sts_next;
         if (wr_done && a_ien && pstrb[0]) begin
            ien_reg <= pwdata[STS_W-1:0];
         end
         irq <= |(sts_next & ien_reg);
      end
   end

   // Toggling gives half the event rate; events fall on time-base ticks only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_pulse <= 1'b0;
      end else if (alm_evt) begin
         alarm_pulse <= !alarm_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_auto_off;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && cfg_reg.rpt == RPT_ZERO && !cfg_reg.chime && !(wr_done && a_cfg))
      |=> !cfg_reg.on;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("alarm stayed on");

   property p_last;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && cfg_reg.rpt == 8'h01 && !cfg_reg.chime && !(wr_done && a_cfg))
      |=> (cfg_reg.on && cfg_reg.rpt == RPT_ZERO);
   endproperty
   a_last: assert property (p_last) else $error("final alarm not armed");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && cfg_reg.rpt == RPT_ZERO && cfg_reg.chime && !(wr_done && a_cfg))
      |=> (cfg_reg.rpt == RPT_FULL && cfg_reg.on);
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap");

   property p_dec;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && cfg_reg.rpt != RPT_ZERO && !(wr_done && a_cfg))
      |=> cfg_reg.rpt == $past(cfg_reg.rpt) - 8'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("count not decremented");

   property p_ptr;
      @(posedge pclk) disable iff (!presetn)
      win_touch |=> cfg_reg.ptr == (($past(cfg_reg.ptr) == PTR_ZERO) ? PTR_ZERO
         : $past(cfg_reg.ptr) - 2'h1);
   endproperty
   a_ptr: assert property (p_ptr) else $error("window pointer wrong");

   property p_win_rd;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && a_val && !pwrite && cfg_reg.ptr == 2'h1)
      |=> (pready && prdata[15:0] == {5'h00, alm_reg.wday, alm_reg.hour});
   endproperty
   a_win_rd: assert property (p_win_rd) else $error("window read wrong");

   property p_min_match;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && cfg_reg.iv == 4'h3) |-> (eval_sec_reg && cur_time.second == alm_reg.second);
   endproperty
   a_min_match: assert property (p_min_match) else $error("minute alarm mismatch");

   property p_leap;
      @(posedge pclk) disable iff (!presetn)
      (cfg_reg.iv == 4'h9 && feb29 && !bcd_leap(cur_time.year)) |-> !alm_evt;
   endproperty
   a_leap: assert property (p_leap) else $error("Feb 29 alarm outside leap year");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (alm_evt && ien_reg[STS_ALARM]) |=> (sts_reg[STS_ALARM] && irq);
   endproperty
   a_irq: assert property (p_irq) else $error("no alarm interrupt");

   property p_pulse;
      @(posedge pclk) disable iff (!presetn)
      ##1 (alarm_pulse != $past(alarm_pulse)) == $past(alm_evt);
   endproperty
   a_pulse: assert property (p_pulse) else $error("alarm pulse wrong");

   c_wrap: cover property (@(posedge pclk) disable iff (!presetn)
      alm_evt && cfg_reg.chime && cfg_reg.rpt == RPT_ZERO);
   c_off: cover property (@(posedge pclk) disable iff (!presetn)
      alm_evt && !cfg_reg.chime && cfg_reg.rpt == RPT_ZERO);
   c_win: cover property (@(posedge pclk) disable iff (!presetn)
      win_touch && cfg_reg.ptr == 2'h2);
   c_year: cover property (@(posedge pclk) disable iff (!presetn)
      alm_evt && cfg_reg.iv == 4'h9);
endmodule : rtcal_top
`default_nettype wire

// File: common/rtcal_pkg.sv
// Constants and types of the RTC alarm and calibration block
package rtcal_pkg;
   // APB byte addresses
   localparam logic [7:0] RA_CFG = 8'h00;
   localparam logic [7:0] RA_VAL = 8'h04;
   localparam logic [7:0] RA_TRIM = 8'h08;
   localparam logic [7:0] RA_STS = 8'h0C;
   localparam logic [7:0] RA_CLR = 8'h10;
   localparam logic [7:0] RA_IEN = 8'h14;
   // Trim register fields
   localparam int TRIM_RUN = 8;
   localparam int TRIM_SYNC = 9;
   // Reset values
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [1:0] STS_RST = 2'h0;
   // Status bits
   localparam int STS_W = 2;
   localparam int STS_ALARM = 0;
   localparam int STS_SEC = 1;
   // Counter values
   localparam logic [7:0] RPT_ZERO = 8'h00;
   localparam logic [7:0] RPT_FULL = 8'hFF;
   localparam logic [1:0] PTR_ZERO = 2'h0;
   // Time base: 32768 ticks a second, sync flag over the last 32 ticks
   localparam logic signed [16:0] CNT_ZERO = 17'sh00000;
   localparam logic signed [16:0] CNT_HALF = 17'sh03FFF;
   localparam logic signed [16:0] CNT_LAST = 17'sh07FFF;
   localparam logic signed [16:0] CNT_SYNC = 17'sh07FE0;
   localparam int CAL_SHIFT = 2;
   // BCD constants
   localparam logic [7:0] BCD_FEB = 8'h02;
   localparam logic [7:0] BCD_D29 = 8'h29;
   localparam logic [7:0] BCD_S59 = 8'h59;

   typedef enum logic [3:0] {
      IV_HALF, IV_SEC, IV_TENSEC, IV_MIN, IV_TENMIN,
      IV_HOUR, IV_DAY, IV_WEEK, IV_MONTH, IV_YEAR
   } rtcal_iv_t;

   // Layout of alarm_config_repeat
   typedef struct packed {
      logic on;
      logic chime;
      logic [3:0] iv;
      logic [1:0] ptr;
      logic [7:0] rpt;
   } rtcal_cfg_t;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] wday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } rtcal_time_t;

   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] wday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } rtcal_alarm_t;

   localparam rtcal_alarm_t ALM_RST = '0;
endpackage : rtcal_pkg

// File: hdl/rtcal_prescale.sv
// Time base prescaler with once-a-minute trim
`timescale 1ns/1ps
`default_nettype none
module rtcal_prescale
   import rtcal_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tb_tick,
   input wire logic run,
   input wire logic cal_apply,
   input wire logic [7:0] trim,
   output logic half_tick,
   output logic sec_tick,
   output logic sync_flag
);
   logic signed [16:0] cnt_reg;
   logic signed [16:0] cal_start;
   logic roll;

   // Signed trim times four; negative starts below zero to stretch the second
   assign cal_start = {{7{trim[7]}}, trim, 2'b00};
   assign roll = run && tb_tick && (cnt_reg == CNT_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= CNT_ZERO;
      end else if (!run) begin
         cnt_reg <= CNT_ZERO;
      end else if (tb_tick) begin
         if (cnt_reg == CNT_LAST) begin
            cnt_reg <= cal_apply ? cal_start : CNT_ZERO;
         end else begin
            cnt_reg <= cnt_reg + 17'sd1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_tick <= 1'b0;
         sec_tick <= 1'b0;
         sync_flag <= 1'b0;
      end else begin
         half_tick <= roll || (run && tb_tick && cnt_reg == CNT_HALF);
         sec_tick <= roll;
         sync_flag <= run && (cnt_reg >= CNT_SYNC);
      end
   end

   property p_cal_load;
      @(posedge pclk) disable iff (!presetn)
      (roll && cal_apply) |=> (!run || cnt_reg == $past(cal_start));
   endproperty
   a_cal_load: assert property (p_cal_load) else $error("trim not applied");

   property p_cal_neg;
      @(posedge pclk) disable iff (!presetn)
      (roll && cal_apply && trim[7]) |=> (!run || cnt_reg < CNT_ZERO);
   endproperty
   a_cal_neg: assert property (p_cal_neg) else $error("negative trim lost");

   c_cal: cover property (@(posedge pclk) disable iff (!presetn) roll && cal_apply && trim[7]);
endmodule : rtcal_prescale
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the RTC alarm and calibration block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import rtcal_pkg::*;
;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tb_tick;
   rtcal_time_t cur_time;
   logic irq;
   logic alarm_pulse;
   logic sec_pulse;
   int n_fail;
   int samples_checked;
   logic [31:0] rdat;
   logic err;

   rtcal_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tb_tick(tb_tick), .cur_time(cur_time), .irq(irq),
      .alarm_pulse(alarm_pulse), .sec_pulse(sec_pulse)
   );

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One APB transfer; waits on pready with no assumed latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'h3;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A slave that never answers is a failure of its own, not just bad data
      if (pready !== 1'b1) begin
         n_fail++;
         $display("unexpected pready: expected 1 seen %b", pready);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] mask,
                         input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r & mask, exp);
   endtask : rd_chk

   // Waits for the alarm output to reach a level; the long bound spans more than one second
   task automatic wait_ap(input logic lvl);
      int n;
      n = 0;
      while (alarm_pulse !== lvl && n < 40000) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_ap

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // Tests need about two seconds of time base (65536 cycles) plus bus traffic
      repeat (90000) @(posedge pclk);
      n_fail++;
      close_out();
   end

   initial begin
      int n;
      n_fail = 0;
      samples_checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      tb_tick = 1'b1;
      cur_time = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;

      // Reset values and access kinds
      rd_chk("cfg reset", RA_CFG, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk("trim reset", RA_TRIM, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk("status reset", RA_STS, 32'hFFFF_FFFF, 32'h0000_0000);
      check("alarm_pulse reset", {31'h0, alarm_pulse}, 32'h0);
      wr(RA_STS, 32'h0000_0003);
      rd_chk("status ro", RA_STS, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk("clear wo", RA_CLR, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h18, 32'h0, rdat, err);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rdat, 32'h0);
      $display("test registers done");

      // Window pointer walk: writes then reads, pointer stops at zero
      wr(RA_CFG, 32'h0000_0200);
      wr(RA_VAL, 32'h0000_0215);
      wr(RA_VAL, 32'h0000_0312);
      wr(RA_VAL, 32'h0000_3045);
      wr(RA_VAL, 32'h0000_3045);
      rd_chk("ptr after writes", RA_CFG, 32'hFFFF, 32'h0000);
      wr(RA_CFG, 32'h0000_0300);
      rd_chk("unimpl field", RA_VAL, 32'hFFFF, 32'h0000);
      rd_chk("month day", RA_VAL, 32'hFFFF, 32'h0215);
      rd_chk("wday hour", RA_VAL, 32'hFFFF, 32'h0312);
      rd_chk("min sec", RA_VAL, 32'hFFFF, 32'h3045);
      rd_chk("min sec again", RA_VAL, 32'hFFFF, 32'h3045);
      rd_chk("ptr stops", RA_CFG, 32'hFFFF, 32'h0000);
      $display("test window done");

      // Repeat count 1, half-second interval: two events then auto-off
      wr(RA_IEN, 32'h0000_0001);
      wr(RA_TRIM, 32'h0000_01FC);
      rd_chk("trim rw", RA_TRIM, 32'h1FF, 32'h1FC);
      wr(RA_CFG, 32'h0000_8001);
      wait_ap(1'b1);
      check("alarm_pulse first", {31'h0, alarm_pulse}, 32'h1);
      check("irq on event", {31'h0, irq}, 32'h1);
      rd_chk("count dec", RA_CFG, 32'hFFFF, 32'h8000);
      rd_chk("status alarm", RA_STS, 32'h1, 32'h1);
      wr(RA_CLR, 32'h0000_0003);
      wr(RA_IEN, 32'h0000_0000);
      rd_chk("status cleared", RA_STS, 32'h1, 32'h0);
      check("irq cleared", {31'h0, irq}, 32'h0);
      wait_ap(1'b0);
      check("alarm_pulse second", {31'h0, alarm_pulse}, 32'h0);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd_chk("final alarm off", RA_CFG, 32'hFFFF, 32'h0000);
      rd_chk("status masked", RA_STS, 32'h1, 32'h1);
      wr(RA_IEN, 32'h0000_0001);
      rd_chk("status held", RA_STS, 32'h1, 32'h1);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      wr(RA_CLR, 32'h0000_0003);
      rd_chk("status clear again", RA_STS, 32'h1, 32'h0);
      check("irq low", {31'h0, irq}, 32'h0);
      $display("test repeat done");

      // Chime at zero count wraps to all ones and stays on
      wr(RA_CFG, 32'h0000_C000);
      wait_ap(1'b1);
      check("alarm_pulse chime", {31'h0, alarm_pulse}, 32'h1);
      rd_chk("chime wrap", RA_CFG, 32'hFFFF, 32'h0000_C0FF);
      $display("test chime done");

      // Ten-second interval, units digit 9 against 5: no event, alarm stays on;
      // second 59 also makes the coming rollover load the negative trim
      wr(RA_CFG, 32'h0000_0800);
      cur_time.second <= 8'h59;
      wr(RA_CFG, 32'h0000_8800);
      n = 0;
      while (sec_pulse !== 1'b1 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      check("sec pulse seen", {31'h0, sec_pulse}, 32'h1);
      repeat (4) @(posedge pclk);
      check("no alarm mismatch", {31'h0, alarm_pulse}, 32'h1);
      rd_chk("cfg kept", RA_CFG, 32'hFFFF, 32'h8800);
      $display("test mismatch done");

      // Reset in mid-run drops the pulse output and the configuration
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("alarm_pulse in reset", {31'h0, alarm_pulse}, 32'h0);
      presetn <= 1'b1;
      rd_chk("cfg after reset", RA_CFG, 32'hFFFF, 32'h0000);
      $display("test reset done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
